/* File: core/fail_pkg.sv */
package fail_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CLK_HZ           = 250_000_000;
  // Blink output period: 1.25 Hz is 800 ms, half of it low.
  localparam int unsigned BLINK_PERIOD_MS  = 800;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_PERIOD_MS / 2 * 250_000;
  // Dimmed output: 100 Hz is 10 ms, 20 percent low.
  localparam int unsigned PWM_PERIOD_US    = 10_000;
  localparam int unsigned PWM_DUTY_PCT     = 20;
  localparam int unsigned PWM_PERIOD_CYC   = PWM_PERIOD_US * CLK_MHZ;
  localparam int unsigned PWM_LOW_CYC      = PWM_PERIOD_CYC * PWM_DUTY_PCT
                                             / 100;
  // Safe input window, longest time, rounded down.
  localparam int unsigned WINDOW_US        = 240;
  localparam int unsigned WINDOW_CYC       = WINDOW_US * CLK_MHZ;
  // Safe input deglitch filter, longest time 1.5 us, in ns, rounded down.
  localparam int unsigned FILTER_NS        = 1500;
  localparam int unsigned FILTER_CYC       = FILTER_NS * CLK_MHZ / 1000;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic        SAFE_INPUT_DISABLE_RST = 1'b0;

endpackage

/* File: core/fail_output_and_fail_safe_input.sv */
// Operation
// - Any failure drives outputs, sets active flag
// - Triggers: watchdog, thermal, supply short, clamp
// - Select bit picks first or second watchdog failure
// - Deactivate when causes gone and flag cleared
// - Watchdog case also needs good trigger, flag cleared
// - Activation independent of fail-safe mode entry
// - All activate together, static output stays low
// - Blink output toggles 1.25 Hz, 50 percent
// - Dimmed output PWM 100 Hz, 20 percent
// - Rising edge required in every 240 us window
// - Supervision default on, disable bit turns off
// - Missed edge sets flag, drives static, dimmed
// - Safe input failure changes no mode, reset
// - Safe flag clear needs a new rising edge
// - Supervision only in normal operating mode
// - Safe input deglitched, at most 1.5 us
// - Watchdog reset sets watchdog failure flag
// - Reset clamp high latched as status flag
`timescale 1ns/1ps
`default_nettype none

module fail_output_and_fail_safe_input
  import fail_pkg::*;
#(
  parameter int unsigned BLINK_HALF  = BLINK_HALF_CYC,
  parameter int unsigned PWM_PERIOD  = PWM_PERIOD_CYC,
  parameter int unsigned PWM_LOW     = PWM_LOW_CYC,
  parameter int unsigned WINDOW      = WINDOW_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Failure sources and operating mode
  input  wire logic watchdog_reset_event,
  input  wire logic watchdog_trigger_ok,
  input  wire logic thermal_shutdown_level_two,
  input  wire logic main_supply_output_short,
  input  wire logic reset_clamp_detect,
  input  wire logic normal_mode,
  // Software control
  input  wire logic watchdog_fail_count_select,
  input  wire logic safe_input_disable_write,
  input  wire logic safe_input_disable_value,
  input  wire logic clear_fail_output_active,
  input  wire logic clear_watchdog_failure,
  input  wire logic clear_safe_input_failure,
  input  wire logic clear_reset_clamp,
  // Status
  output logic      fail_output_active_flag,
  output logic      watchdog_failure_flag,
  output logic      safe_input_failure_flag,
  output logic      reset_clamp_high_flag,
  output logic      safe_input_disable,
  // Fail output pins, enable low drives the pin low
  output logic      static_fail_output_oe_n,
  output logic      blink_fail_output_oe_n,
  output logic      dimmed_fail_output_oe_n,
  output logic      blink_fail_output_out,
  input  wire logic safe_input_pin
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic        fo_reg, fo_next;
  logic [1:0]  wd_cnt_reg, wd_cnt_next;
  logic        wd_reg, wd_next;
  logic        wd_ok_reg, wd_ok_next;
  logic        fsi_reg, fsi_next;
  logic        fsi_edge_reg, fsi_edge_next;
  logic        clamp_reg, clamp_next;
  logic        dis_reg, dis_next;
  logic [2:0]  sync_reg, sync_next;
  logic        filt_reg, filt_next;
  logic [15:0] filt_cnt_reg, filt_cnt_next;
  logic [31:0] win_cnt_reg, win_cnt_next;
  logic [31:0] blink_cnt_reg, blink_cnt_next;
  logic        blink_reg, blink_next;
  logic [31:0] pwm_cnt_reg, pwm_cnt_next;
  logic        fo1_reg, fo1_next, fo2_reg, fo2_next, fo3_reg, fo3_next;
  logic        wd_trig, cond, rise, sup_on, any_fo;

  // ---------------------------------------------------------------------------
  // Failure logic
  // ---------------------------------------------------------------------------
  always_comb begin
    sup_on = normal_mode && !dis_reg;
    rise   = sync_reg[2] == sync_reg[1] && sync_reg[2] && !filt_reg
             && filt_cnt_reg == 16'(FILTER_CYC);
    // Watchdog failures count; select picks one or two.
    wd_cnt_next = wd_cnt_reg;
    if (watchdog_reset_event && wd_cnt_reg != 2'd2) begin
      wd_cnt_next = wd_cnt_reg + 2'd1;
    end else if (clear_watchdog_failure && !watchdog_reset_event
                 && wd_ok_reg) begin
      wd_cnt_next = 2'd0;
    end
    wd_trig = watchdog_fail_count_select ? (wd_cnt_reg >= 2'd2)
                                         : (wd_cnt_reg >= 2'd1);
    wd_next = watchdog_reset_event || (wd_reg && !(clear_watchdog_failure
              && wd_ok_reg));
    wd_ok_next = watchdog_reset_event ? 1'b0
                 : (wd_ok_reg || watchdog_trigger_ok);
    clamp_next = reset_clamp_detect
                 || (clamp_reg && !clear_reset_clamp);
    cond = (wd_trig && wd_reg) || thermal_shutdown_level_two
           || main_supply_output_short || clamp_reg;
    // Set wins over clear; clear only with causes gone.
    fo_next = cond || (fo_reg && !clear_fail_output_active);
    dis_next = safe_input_disable_write ? safe_input_disable_value
                                        : dis_reg;
    // Deglitch filter on the safe input.
    sync_next = {sync_reg[1:0], safe_input_pin};
    filt_next = filt_reg;
    filt_cnt_next = 16'd0;
    if (sync_reg[2] == sync_reg[1] && sync_reg[2] != filt_reg) begin
      filt_cnt_next = filt_cnt_reg + 16'd1;
      if (filt_cnt_reg == 16'(FILTER_CYC)) begin
        filt_next = sync_reg[2];
        filt_cnt_next = 16'd0;
      end
    end
    // Window supervision.
    win_cnt_next = 32'd0;
    fsi_next = fsi_reg;
    fsi_edge_next = fsi_edge_reg || rise;
    if (sup_on && !any_fo) begin
      win_cnt_next = rise ? 32'd0 : win_cnt_reg + 32'd1;
      if (!rise && win_cnt_reg + 32'd1 >= WINDOW) begin
        fsi_next = 1'b1;
        fsi_edge_next = 1'b0;
        win_cnt_next = 32'd0;
      end
    end else if (sup_on && fsi_reg && rise) begin
      win_cnt_next = 32'd0;
    end
    // A miss in the same cycle zeroes the edge record, so the set wins.
    if (clear_safe_input_failure && fsi_edge_reg && fsi_reg
        && fsi_edge_next) begin
      fsi_next = 1'b0;
      fsi_edge_next = 1'b0;
    end
    if (fsi_reg && !fsi_next) begin
      win_cnt_next = 32'd0;
    end
  end
  // The window counter is held at zero while fail outputs own the pin.
  assign any_fo = fo_reg;

  // ---------------------------------------------------------------------------
  // Output timing
  // ---------------------------------------------------------------------------
  always_comb begin
    blink_cnt_next = 32'd0;
    blink_next = 1'b1;
    pwm_cnt_next = 32'd0;
    if (fo_reg) begin
      blink_next = blink_reg;
      blink_cnt_next = blink_cnt_reg + 32'd1;
      if (blink_cnt_reg + 32'd1 >= BLINK_HALF) begin
        blink_cnt_next = 32'd0;
        blink_next = !blink_reg;
      end
    end
    if (fo_reg || fsi_reg) begin
      pwm_cnt_next = (pwm_cnt_reg + 32'd1 >= PWM_PERIOD) ? 32'd0
                     : pwm_cnt_reg + 32'd1;
    end
    fo1_next = fo_reg || fsi_reg;
    fo2_next = fo_reg && blink_reg;
    fo3_next = (fo_reg || fsi_reg) && pwm_cnt_reg < PWM_LOW;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fo_reg <= 1'b0;
      wd_cnt_reg <= 2'd0;
      wd_reg <= 1'b0;
      wd_ok_reg <= 1'b0;
      fsi_reg <= 1'b0;
      fsi_edge_reg <= 1'b0;
      clamp_reg <= 1'b0;
      dis_reg <= SAFE_INPUT_DISABLE_RST;
      sync_reg <= 3'b111;
      filt_reg <= 1'b1;
      filt_cnt_reg <= 16'd0;
      win_cnt_reg <= 32'd0;
      blink_cnt_reg <= 32'd0;
      blink_reg <= 1'b1;
      pwm_cnt_reg <= 32'd0;
      fo1_reg <= 1'b0;
      fo2_reg <= 1'b0;
      fo3_reg <= 1'b0;
    end else begin
      fo_reg <= fo_next;
      wd_cnt_reg <= wd_cnt_next;
      wd_reg <= wd_next;
      wd_ok_reg <= wd_ok_next;
      fsi_reg <= fsi_next;
      fsi_edge_reg <= fsi_edge_next;
      clamp_reg <= clamp_next;
      dis_reg <= dis_next;
      sync_reg <= sync_next;
      filt_reg <= filt_next;
      filt_cnt_reg <= filt_cnt_next;
      win_cnt_reg <= win_cnt_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
      pwm_cnt_reg <= pwm_cnt_next;
      fo1_reg <= fo1_next;
      fo2_reg <= fo2_next;
      fo3_reg <= fo3_next;
    end
  end

  assign fail_output_active_flag = fo_reg;
  assign watchdog_failure_flag   = wd_reg;
  assign safe_input_failure_flag = fsi_reg;
  assign reset_clamp_high_flag   = clamp_reg;
  assign safe_input_disable      = dis_reg;
  assign static_fail_output_oe_n = !fo1_reg;
  assign blink_fail_output_oe_n  = !fo2_reg;
  assign dimmed_fail_output_oe_n = !fo3_reg;
  assign blink_fail_output_out   = 1'b0;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_thermal_sets_active: assert property (@(posedge ref_clk) disable iff
    (!rst_n) thermal_shutdown_level_two |=> fail_output_active_flag)
    else $error("thermal failure did not set active flag");
  a_active_drives_static: assert property (@(posedge ref_clk) disable iff
    (!rst_n) $rose(fo_reg) |=> !static_fail_output_oe_n)
    else $error("static output not driven after activation");
  a_clear_needs_idle: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (fo_reg && cond) |=> fo_reg)
    else $error("active flag cleared while failure present");
  a_wd_clear_gated: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (wd_reg && !wd_ok_reg) |=> wd_reg)
    else $error("watchdog flag cleared without good trigger");
  a_blink_off_idle: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (!fo_reg && !fo2_reg) |=> blink_fail_output_oe_n)
    else $error("blink pin driven while inactive");
  a_pwm_low_duty: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (fo_reg && $past(fo_reg) && pwm_cnt_reg >= PWM_LOW)
    |=> dimmed_fail_output_oe_n)
    else $error("dimmed output driven outside duty");
  a_fsi_clear_edge: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (fsi_reg && !fsi_edge_reg) |=> fsi_reg)
    else $error("safe input flag cleared without edge");
  a_window_limit: assert property (@(posedge ref_clk) disable iff
    (!rst_n) win_cnt_reg < WINDOW)
    else $error("window counter passed its limit");
  a_supervision_mode: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (!normal_mode || dis_reg) |=> win_cnt_reg == 32'd0)
    else $error("window ran outside normal mode");
  a_any_sets_active: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (main_supply_output_short || clamp_reg)
    |=> fail_output_active_flag)
    else $error("failure did not set active flag");
  a_first_wd_select: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (!watchdog_fail_count_select && wd_reg
    && wd_cnt_reg >= 2'd1) |=> fo_reg)
    else $error("first watchdog failure did not activate");
  a_second_wd_wait: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (watchdog_fail_count_select && wd_cnt_reg == 2'd1 && !fo_reg
    && !thermal_shutdown_level_two && !main_supply_output_short
    && !clamp_reg) |=> !fo_reg)
    else $error("activated before second watchdog failure");
  a_wd_ok_clears: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (clear_watchdog_failure && wd_ok_reg && !watchdog_reset_event)
    |=> !wd_reg)
    else $error("watchdog flag not cleared after good trigger");
  a_blink_hold: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (fo_reg && blink_cnt_reg + 32'd1 < BLINK_HALF)
    |=> $stable(blink_reg))
    else $error("blink phase changed early");
  a_blink_toggle: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (fo_reg && blink_cnt_reg + 32'd1 >= BLINK_HALF)
    |=> $changed(blink_reg))
    else $error("blink phase did not toggle");
  a_miss_sets_flag: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (sup_on && !any_fo && !rise && win_cnt_reg + 32'd1 >= WINDOW)
    |=> safe_input_failure_flag)
    else $error("missed edge did not set safe flag");
  a_safe_drives_static: assert property (@(posedge ref_clk) disable iff
    (!rst_n) fsi_reg |=> !static_fail_output_oe_n)
    else $error("static output not driven on safe failure");
  a_pwm_drive_duty: assert property (@(posedge ref_clk) disable iff
    (!rst_n) ((fo_reg || fsi_reg) && pwm_cnt_reg < PWM_LOW)
    |=> !dimmed_fail_output_oe_n)
    else $error("dimmed output not driven inside duty");
  a_filter_holds: assert property (@(posedge ref_clk) disable iff
    (!rst_n) (sync_reg[2] != sync_reg[1]) |=> $stable(filt_reg))
    else $error("filter followed an unsettled input");
  a_disable_write: assert property (@(posedge ref_clk) disable iff
    (!rst_n) safe_input_disable_write
    |=> safe_input_disable == $past(safe_input_disable_value))
    else $error("disable bit not written");
  a_idle_counters: assert property (@(posedge ref_clk) disable iff
    (!rst_n) !fo_reg |=> blink_cnt_reg == 32'd0)
    else $error("blink counter ran while inactive");

endmodule

`default_nettype wire

/* File: bench/safe_input_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Microcontroller safe-input square wave; released high when stopped.
// ----------------------------------------------------------------------
module safe_input_host (
  // Control
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic [31:0] high_cyc,
  // Pin drive
  output logic      mcu_level
);
  int cnt;
  initial cnt = 0;
  initial mcu_level = 1'h1;
  always @(posedge ref_clk) begin
    if (!run) begin
      cnt       <= 0;
      mcu_level <= 1'h1;
    end else begin
      cnt       <= (cnt + 1 >= 2 * high_cyc) ? 0 : cnt + 1;
      mcu_level <= (cnt < high_cyc);
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Fail output and safe input bench
// ----------------------------------------------------------------------
module testbench;
  localparam int BH = 20;
  localparam int PP = 50;
  localparam int PL = 10;
  localparam int WN = 2000;
  localparam int WEV = 0, WOK = 1, CFO = 2, CWD = 3, CSI = 4, CCL = 5;
  localparam int CLD = 6, DWR = 7;
  logic        ref_clk, rst_n, tsd, vsh, nmode, wsel, dval, run;
  logic [7:0]  pls;
  logic        fo_f, wd_f, si_f, cl_f, si_dis, st_n, bl_n, dm_n, bl_o, mcu;
  wire logic   pin = bl_n ? mcu : bl_o;
  int          high_cyc, fail_count, total_checks, lb, ld;
  logic [31:0] seed;

  fail_output_and_fail_safe_input #(.BLINK_HALF(BH), .PWM_PERIOD(PP),
    .PWM_LOW(PL), .WINDOW(WN)) u_fail_output_and_fail_safe_input (
    .ref_clk(ref_clk), .rst_n(rst_n), .watchdog_reset_event(pls[WEV]),
    .watchdog_trigger_ok(pls[WOK]), .thermal_shutdown_level_two(tsd),
    .main_supply_output_short(vsh), .reset_clamp_detect(pls[CLD]),
    .normal_mode(nmode), .watchdog_fail_count_select(wsel),
    .safe_input_disable_write(pls[DWR]), .safe_input_disable_value(dval),
    .clear_fail_output_active(pls[CFO]), .clear_watchdog_failure(pls[CWD]),
    .clear_safe_input_failure(pls[CSI]), .clear_reset_clamp(pls[CCL]),
    .fail_output_active_flag(fo_f), .watchdog_failure_flag(wd_f),
    .safe_input_failure_flag(si_f), .reset_clamp_high_flag(cl_f),
    .safe_input_disable(si_dis), .static_fail_output_oe_n(st_n),
    .blink_fail_output_oe_n(bl_n), .dimmed_fail_output_oe_n(dm_n),
    .blink_fail_output_out(bl_o), .safe_input_pin(pin));

  safe_input_host u_safe_input_host (.ref_clk(ref_clk), .run(run),
    .high_cyc(high_cyc), .mcu_level(mcu));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic a, input logic e, input string m);
    total_checks++;
    if (a !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cnt_chk(input int a, input int e, input string m);
    total_checks++;
    if (a != e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %0d", $time, m, a);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    pls[i] <= 1'h1;
    @(posedge ref_clk);
    pls[i] <= 1'h0;
    #1;
  endtask

  // Counts cycles with blink and dimmed pins driven.
  task automatic count_low(input int n);
    lb = 0;
    ld = 0;
    repeat (n) begin
      tick(1);
      lb += int'(!bl_n);
      ld += int'(!dm_n);
    end
  endtask

  // Counts cycles with the safe failure flag up and blink driven.
  task automatic quiet(input int n);
    lb = 0;
    ld = 0;
    repeat (n) begin
      tick(1);
      lb += int'(si_f);
      ld += int'(!bl_n);
    end
  endtask

  task automatic wait_si(input int lim);
    for (int i = 0; i < lim && si_f !== 1'h1; i++) tick(1);
  endtask

  task automatic src_test(input int k);
    @(posedge ref_clk);
    if (k == 0) tsd <= 1'h1;
    else if (k == 1) vsh <= 1'h1;
    else pls[CLD] <= 1'h1;
    @(posedge ref_clk);
    pls[CLD] <= 1'h0;
    tick(3);
    chk(fo_f, 1'h1, "active flag");
    chk(st_n, 1'h0, "static drive");
    if (k == 2) chk(cl_f, 1'h1, "clamp flag");
    count_low(200);
    cnt_chk(lb, 100, "blink low");
    cnt_chk(ld, 200 * PL / PP, "dim low");
    pulse(CFO);
    tick(1 + int'(rnd() % 4));
    chk(fo_f, 1'h1, "clear refused");
    @(posedge ref_clk);
    tsd <= 1'h0;
    vsh <= 1'h0;
    pulse(CCL);
    pulse(CFO);
    tick(3);
    chk(fo_f | ~st_n | ~bl_n | ~dm_n, 1'h0, "release");
    $display("test source %0d done", k);
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    #400000;
    fail_count++;
    $display("[FAIL] %0t timeout", $time);
    conclude();
  end

  initial begin
    {rst_n, tsd, vsh, nmode, wsel, dval, run} = 7'h00;
    pls = 8'h00;
    high_cyc = 500;
    fail_count = 0;
    total_checks = 0;
    seed = 32'hb7b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    tick(1);
    chk(fo_f | wd_f | si_f | cl_f | si_dis, 1'h0, "reset flags");
    chk(st_n & bl_n & dm_n, 1'h1, "reset pins");
    for (int k = 0; k < 3; k++) src_test(k);
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      wsel <= s[0];
      pulse(WEV);
      tick(2);
      chk(wd_f, 1'h1, "wd flag");
      chk(fo_f, s == 0, "first fail");
      pulse(WEV);
      tick(2);
      chk(fo_f, 1'h1, "second fail");
      pulse(CWD);
      pulse(CFO);
      tick(2);
      chk(fo_f & wd_f, 1'h1, "wd hold");
      pulse(WOK);
      pulse(CWD);
      pulse(CFO);
      tick(3);
      chk(fo_f | wd_f | ~st_n, 1'h0, "wd release");
    end
    $display("test watchdog done");
    @(posedge ref_clk);
    high_cyc <= 450 + int'(rnd() % 100);
    run <= 1'h1;
    nmode <= 1'h1;
    quiet(3 * WN);
    cnt_chk(lb, 0, "window fail");
    cnt_chk(ld, 0, "blink pin driven");
    @(posedge ref_clk);
    run <= 1'h0;
    wait_si(WN + 1000);
    tick(2);
    chk(si_f & ~st_n & ~dm_n, 1'h1, "missed edge");
    pulse(CSI);
    tick(2);
    chk(si_f, 1'h1, "clear needs edge");
    @(posedge ref_clk);
    run <= 1'h1;
    tick(1500);
    pulse(CSI);
    tick(3);
    chk(si_f | ~st_n, 1'h0, "safe clear");
    @(posedge ref_clk);
    high_cyc <= 100;
    wait_si(2 * WN + 1000);
    chk(si_f, 1'h1, "glitch rejected");
    @(posedge ref_clk);
    high_cyc <= 500;
    tick(1500);
    pulse(CSI);
    $display("test safe input done");
    @(posedge ref_clk);
    run <= 1'h0;
    dval <= 1'h1;
    pulse(DWR);
    tick(1);
    chk(si_dis, 1'h1, "disable set");
    quiet(3 * WN);
    cnt_chk(lb, 0, "disabled");
    @(posedge ref_clk);
    dval <= 1'h0;
    pulse(DWR);
    @(posedge ref_clk);
    nmode <= 1'h0;
    quiet(3 * WN);
    cnt_chk(lb, 0, "other mode");
    $display("test disable and mode done");
    conclude();
  end
endmodule
`default_nettype wire
